/* File: core/drive_homing_sequencer.sv */
// Drive state machine and homing control behind an AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
module drive_homing_sequencer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] act_pos,
  input  wire logic        home_sw,
  output      logic [31:0] speed_cmd,
  output      logic        dir_neg,
  output      logic        ref_load,
  output      logic [31:0] ref_pos
);

  drive_homing_pkg::state_t s;
  drive_homing_pkg::state_t n;

  logic        wr_fire;
  logic        mode_wr;
  logic [7:0]  mode_val;
  logic        home_req;
  logic        home_ok;
  logic        sw_act;
  logic        sw_fall;
  logic        sw_rise;
  logic [31:0] rd_word;
  logic [31:0] pos_next;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Request decode and switch edges
  assign wr_fire  = s.aw_got && s.w_got && !s.bvalid;
  assign mode_wr  = wr_fire && (s.waddr == drive_homing_pkg::OFS_MODE_REQ) && s.wstrb[0];
  assign mode_val = s.wdata[7:0];
  assign home_req = mode_wr && (mode_val == drive_homing_pkg::MODE_HOMING);
  assign home_ok  = home_req && (s.drive == drive_homing_pkg::DRV_ENABLED)
                 && (s.mode_act == drive_homing_pkg::MODE_POSITION)
                 && (s.hstate == drive_homing_pkg::HM_IDLE);
  assign sw_act   = s.sw_sync ^ s.sw_pol;
  assign sw_fall  = s.sw_prev && !sw_act;
  assign sw_rise  = !s.sw_prev && sw_act;
  // Where the axis lands after the step that the present speed output commands
  assign pos_next = s.dir_neg ? act_pos - s.speed : act_pos + s.speed;

  // Read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      drive_homing_pkg::OFS_CTRL:        rd_word = {28'h0000000, s.cmd};
      drive_homing_pkg::OFS_STATUS: begin
        rd_word[drive_homing_pkg::STAT_DRIVE_LSB +: 2] = s.drive;
        rd_word[drive_homing_pkg::STAT_HOMING] = (s.hstate != drive_homing_pkg::HM_IDLE);
      end
      drive_homing_pkg::OFS_MODE_REQ:    rd_word = {24'h000000, s.mode_req};
      drive_homing_pkg::OFS_MODE_ACT:    rd_word = {24'h000000, s.mode_act};
      drive_homing_pkg::OFS_HOME_METHOD: rd_word = {24'h000000, s.method};
      drive_homing_pkg::OFS_HOME_POL:    rd_word = {31'h00000000, s.sw_pol};
      drive_homing_pkg::OFS_HOME_TARGET: rd_word = s.target;
      drive_homing_pkg::OFS_HOME_V1:     rd_word = s.v1;
      drive_homing_pkg::OFS_HOME_V2:     rd_word = s.v2;
      drive_homing_pkg::OFS_HOME_OFFSET: rd_word = s.offset;
      drive_homing_pkg::OFS_TARGET_VEL:  rd_word = s.tvel;
      drive_homing_pkg::OFS_REF_POS:     rd_word = s.ref_pos;
      drive_homing_pkg::OFS_ACT_POS:     rd_word = act_pos;
      default:                           rd_word = 32'h0000_0000;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    n          = s;
    n.ref_load = 1'b0;
    n.sw_meta  = home_sw;
    n.sw_sync  = s.sw_meta;
    n.sw_prev  = sw_act;
    // Write address and data, taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.waddr  = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = drive_homing_pkg::RESP_OKAY;
      case (s.waddr)
        drive_homing_pkg::OFS_CTRL:        n.cmd = s.wstrb[0] ? s.wdata[3:0] : s.cmd;
        drive_homing_pkg::OFS_MODE_REQ:    n.mode_req = s.wstrb[0] ? s.wdata[7:0] : s.mode_req;
        drive_homing_pkg::OFS_HOME_METHOD: n.method = s.wstrb[0] ? s.wdata[7:0] : s.method;
        drive_homing_pkg::OFS_HOME_POL:    n.sw_pol = s.wstrb[0] ? s.wdata[0] : s.sw_pol;
        drive_homing_pkg::OFS_HOME_TARGET: n.target = merge(s.target, s.wdata, s.wstrb);
        drive_homing_pkg::OFS_HOME_V1:     n.v1 = merge(s.v1, s.wdata, s.wstrb);
        drive_homing_pkg::OFS_HOME_V2:     n.v2 = merge(s.v2, s.wdata, s.wstrb);
        drive_homing_pkg::OFS_HOME_OFFSET: n.offset = merge(s.offset, s.wdata, s.wstrb);
        drive_homing_pkg::OFS_TARGET_VEL:  n.tvel = merge(s.tvel, s.wdata, s.wstrb);
        drive_homing_pkg::OFS_STATUS,
        drive_homing_pkg::OFS_MODE_ACT,
        drive_homing_pkg::OFS_REF_POS,
        drive_homing_pkg::OFS_ACT_POS:     n.bresp = drive_homing_pkg::RESP_OKAY;
        default:                           n.bresp = drive_homing_pkg::RESP_SLVERR;
      endcase
    end
    // Read channel, one cycle to answer
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rdata  = rd_word;
      n.rresp  = (s_axi_araddr > drive_homing_pkg::OFS_ACT_POS || s_axi_araddr[1:0] != 2'h0)
                 ? drive_homing_pkg::RESP_SLVERR : drive_homing_pkg::RESP_OKAY;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    n.arready = !n.rvalid;
    // Drive power states from the stored command
    if (!s.cmd[drive_homing_pkg::CMD_VOLTAGE_BIT]) begin
      n.drive = drive_homing_pkg::DRV_DISABLED;
    end else if (s.cmd[2:0] == drive_homing_pkg::CMD_SHUTDOWN_LO) begin
      n.drive = drive_homing_pkg::DRV_READY;
    end else if (s.cmd == drive_homing_pkg::CMD_SWITCH_ON
                 && s.drive == drive_homing_pkg::DRV_READY) begin
      n.drive = drive_homing_pkg::DRV_SWITCHED_ON;
    end else if (s.cmd == drive_homing_pkg::CMD_ENABLE_OP
                 && s.drive == drive_homing_pkg::DRV_SWITCHED_ON) begin
      n.drive = drive_homing_pkg::DRV_ENABLED;
    end else begin
      n.drive = s.drive;
    end
    // Positioning mode request, accepted whenever no homing runs
    if (mode_wr && mode_val == drive_homing_pkg::MODE_POSITION
        && s.hstate == drive_homing_pkg::HM_IDLE) begin
      n.mode_act = drive_homing_pkg::MODE_POSITION;
    end
    // Homing sequencer
    case (s.hstate)
      drive_homing_pkg::HM_IDLE: begin
        if (home_ok && s.method == drive_homing_pkg::METHOD_CURPOS) begin
          n.mode_act = drive_homing_pkg::MODE_HOMING;
          n.ref_pos  = act_pos + s.offset;
          n.ref_load = 1'b1;
          n.hstate   = drive_homing_pkg::HM_DONE;
        end else if (home_ok && s.method == drive_homing_pkg::METHOD_SWITCH) begin
          n.mode_act = drive_homing_pkg::MODE_HOMING;
          n.speed    = s.v1;
          n.dir_neg  = s.target[31];
          n.hstate   = drive_homing_pkg::HM_FAST_FWD;
        end
      end
      drive_homing_pkg::HM_FAST_FWD: begin
        if (sw_fall) begin
          n.dir_neg = !s.target[31];
          n.hstate  = drive_homing_pkg::HM_FAST_REV;
        end
      end
      drive_homing_pkg::HM_FAST_REV: begin
        if (sw_fall) begin
          n.dir_neg = s.target[31];
          n.speed   = s.v2;
          n.hstate  = drive_homing_pkg::HM_SLOW;
        end
      end
      drive_homing_pkg::HM_SLOW: begin
        if (sw_rise) begin
          n.ref_pos = act_pos;
          n.hstate  = drive_homing_pkg::HM_GOTO;
        end
      end
      drive_homing_pkg::HM_GOTO: begin
        // Judged from the landing point: the axis already moves on this cycle's
        // speed, so testing act_pos itself would overshoot by one step.
        // A step width that never lands on the reference keeps hunting around it.
        n.dir_neg = $signed(pos_next) > $signed(s.ref_pos);
        if (pos_next == s.ref_pos) begin
          n.speed    = 32'h0000_0000;
          n.ref_load = 1'b1;
          n.hstate   = drive_homing_pkg::HM_DONE;
        end
      end
      drive_homing_pkg::HM_DONE: begin
        n.speed    = 32'h0000_0000;
        n.mode_act = drive_homing_pkg::MODE_POSITION;
        n.hstate   = drive_homing_pkg::HM_IDLE;
      end
      default: n.hstate = drive_homing_pkg::HM_IDLE;
    endcase
    // Leaving operation-enabled aborts any motion
    if (s.drive != drive_homing_pkg::DRV_ENABLED) begin
      n.speed = 32'h0000_0000;
      if (s.hstate != drive_homing_pkg::HM_IDLE) begin
        n.hstate   = drive_homing_pkg::HM_IDLE;
        n.mode_act = drive_homing_pkg::MODE_POSITION;
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= drive_homing_pkg::STATE_RESET;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign speed_cmd     = s.speed;
  assign dir_neg       = s.dir_neg;
  assign ref_load      = s.ref_load;
  assign ref_pos       = s.ref_pos;

  // Checks on the drive and homing behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence curpos_start;
    home_ok && s.method == drive_homing_pkg::METHOD_CURPOS;
  endsequence

  sequence curpos_finish;
    (s.mode_act == drive_homing_pkg::MODE_HOMING
     && s.ref_pos == $past(act_pos) + $past(s.offset) && s.ref_load)
    ##1 (s.mode_act == drive_homing_pkg::MODE_POSITION);
  endsequence

  a_disable_cmd: assert property (!s.cmd[1] |=> s.drive == drive_homing_pkg::DRV_DISABLED)
    else $error("disable command did not reach disabled state");
  a_shutdown_cmd: assert property (s.cmd[2:0] == 3'h6 |=> s.drive == drive_homing_pkg::DRV_READY)
    else $error("shutdown did not reach ready state");
  a_switch_on: assert property (s.cmd == 4'h7 && s.drive == drive_homing_pkg::DRV_READY
    |=> s.drive == drive_homing_pkg::DRV_SWITCHED_ON) else $error("switch on failed");
  a_enable_op: assert property (s.cmd == 4'hf && s.drive == drive_homing_pkg::DRV_SWITCHED_ON
    |=> s.drive == drive_homing_pkg::DRV_ENABLED) else $error("enable operation failed");
  a_illegal_hold: assert property (s.cmd == 4'hf && s.drive == drive_homing_pkg::DRV_READY
    |=> s.drive == drive_homing_pkg::DRV_READY) else $error("illegal command changed state");
  a_motion_gate: assert property (s.drive != drive_homing_pkg::DRV_ENABLED
    |=> speed_cmd == 32'h0000_0000) else $error("motion while not enabled");
  a_curpos_home: assert property (curpos_start |=> curpos_finish)
    else $error("current position homing wrong");
  a_switch_start: assert property (home_ok && s.method == drive_homing_pkg::METHOD_SWITCH
    |=> s.hstate == drive_homing_pkg::HM_FAST_FWD && speed_cmd == $past(s.v1))
    else $error("switch homing did not start");
  a_home_ignore: assert property (home_req && s.hstate == drive_homing_pkg::HM_IDLE
    && (s.drive != drive_homing_pkg::DRV_ENABLED || s.mode_act != drive_homing_pkg::MODE_POSITION)
    |=> $stable(s.mode_act)) else $error("homing request not ignored");
  a_reverse_fast: assert property (s.hstate == drive_homing_pkg::HM_FAST_FWD && sw_fall
    && s.drive == drive_homing_pkg::DRV_ENABLED |=> s.hstate == drive_homing_pkg::HM_FAST_REV
    && dir_neg != $past(dir_neg) && speed_cmd == $past(s.v1)) else $error("no fast reversal");
  a_latch_ref: assert property (s.hstate == drive_homing_pkg::HM_SLOW && sw_rise
    && s.drive == drive_homing_pkg::DRV_ENABLED |=> ref_pos == $past(act_pos)
    && speed_cmd == $past(s.v2)) else $error("reference not latched");

endmodule

/* File: core/drive_homing_pkg.sv */
// Constants, register map and state types of the drive homing sequencer
package drive_homing_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL        = 8'h00;
  localparam logic [7:0] OFS_STATUS      = 8'h04;
  localparam logic [7:0] OFS_MODE_REQ    = 8'h08;
  localparam logic [7:0] OFS_MODE_ACT    = 8'h0c;
  localparam logic [7:0] OFS_HOME_METHOD = 8'h10;
  localparam logic [7:0] OFS_HOME_POL    = 8'h14;
  localparam logic [7:0] OFS_HOME_TARGET = 8'h18;
  localparam logic [7:0] OFS_HOME_V1     = 8'h1c;
  localparam logic [7:0] OFS_HOME_V2     = 8'h20;
  localparam logic [7:0] OFS_HOME_OFFSET = 8'h24;
  localparam logic [7:0] OFS_TARGET_VEL  = 8'h28;
  localparam logic [7:0] OFS_REF_POS     = 8'h2c;
  localparam logic [7:0] OFS_ACT_POS     = 8'h30;

  // Status field positions
  localparam int STAT_DRIVE_LSB = 0;
  localparam int STAT_HOMING    = 4;

  // Command patterns on the low four control bits
  localparam logic [2:0] CMD_SHUTDOWN_LO = 3'h6;
  localparam logic [3:0] CMD_SWITCH_ON   = 4'h7;
  localparam logic [3:0] CMD_ENABLE_OP   = 4'hf;
  localparam int         CMD_VOLTAGE_BIT = 1;

  // Operating modes and homing methods
  localparam logic [7:0] MODE_NONE     = 8'h00;
  localparam logic [7:0] MODE_POSITION = 8'h01;
  localparam logic [7:0] MODE_HOMING   = 8'h06;
  localparam logic [7:0] METHOD_SWITCH = 8'h11;
  localparam logic [7:0] METHOD_CURPOS = 8'h25;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {DRV_DISABLED, DRV_READY, DRV_SWITCHED_ON, DRV_ENABLED} drive_t;

  typedef enum logic [2:0] {
    HM_IDLE, HM_FAST_FWD, HM_FAST_REV, HM_SLOW, HM_GOTO, HM_DONE
  } home_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [3:0]  cmd;
    drive_t      drive;
    logic [7:0]  mode_req;
    logic [7:0]  mode_act;
    logic [7:0]  method;
    logic        sw_pol;
    logic [31:0] target;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] offset;
    logic [31:0] tvel;
    logic [31:0] ref_pos;
    home_t       hstate;
    logic [31:0] speed;
    logic        dir_neg;
    logic        ref_load;
    logic        sw_meta;
    logic        sw_sync;
    logic        sw_prev;
  } state_t;

  // All fields clear after reset; the drive starts disabled with no mode
  localparam state_t STATE_RESET = '0;

endpackage

/* File: tb/axis_model.sv */
// Axis model: integrates the commanded speed and drives a homing switch window
`timescale 1ns/100ps
module axis_model #(
  parameter logic [31:0] START_POS = 32'h0000_0020,
  parameter logic [31:0] SW_LO     = 32'h0000_0064,
  parameter logic [31:0] SW_HI     = 32'h0000_008c
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] speed_cmd,
  input  wire logic        dir_neg,
  output      logic [31:0] act_pos,
  output      logic        home_sw
);
  // Position follows speed and direction; switch active high inside the window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_pos <= START_POS;
      home_sw <= 1'b0;
    end else begin
      act_pos <= dir_neg ? act_pos - speed_cmd : act_pos + speed_cmd;
      home_sw <= (act_pos >= SW_LO) && (act_pos <= SW_HI);
    end
  end
endmodule

/* File: tb/tb_drive_homing_sequencer.sv */
// Self-checking bench for the drive homing sequencer
`timescale 1ns/100ps
module tb_drive_homing_sequencer;
  localparam logic [31:0] START_POS = 32'h0000_0020;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [31:0] act_pos;
  logic [31:0] speed_cmd;
  logic [31:0] ref_pos;
  logic        home_sw;
  logic        dir_neg;
  logic        ref_load;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          n_fail        = 0;
  int          total_checks  = 0;
  int          cycles        = 0;
  int          n_load        = 0;
  int          i;
  int          k;
  int          n;
  bit          seen_rev      = 1'b0;
  bit          seen_slow     = 1'b0;
  logic [3:0]  cmd_tab [11]  = '{4'h7, 4'h6, 4'hf, 4'h7, 4'hf, 4'he, 4'h7, 4'h5, 4'he, 4'h7, 4'hf};
  logic [1:0]  st_tab [11]   = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h3};

  // Clock generator
  always #4 aclk = ~aclk;

  drive_homing_sequencer i_drive_homing_sequencer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .act_pos(act_pos),
    .home_sw(home_sw), .speed_cmd(speed_cmd), .dir_neg(dir_neg), .ref_load(ref_load),
    .ref_pos(ref_pos));

  axis_model #(.START_POS(START_POS)) i_axis_model (
    .aclk(aclk), .aresetn(aresetn), .speed_cmd(speed_cmd), .dir_neg(dir_neg),
    .act_pos(act_pos), .home_sw(home_sw));

  // Closing verdict
  task automatic final_report();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Word and response comparisons
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t response %h expected %h", $time, got, exp);
    end
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open  = 1'b1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready === 1'b1) begin
        aw_open = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        w_open = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, rs);
    chk_resp(rs, drive_homing_pkg::RESP_OKAY);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a, rd, rs);
    chk_resp(rs, drive_homing_pkg::RESP_OKAY);
    chk32(rd, exp);
  endtask

  // Watchdog and output monitors
  always @(posedge aclk) begin
    cycles++;
    if (ref_load === 1'b1) n_load++;
    if (dir_neg === 1'b1 && speed_cmd === 32'h0000_0004) seen_rev = 1'b1;
    if (speed_cmd === 32'h0000_0001) seen_slow = 1'b1;
    if (cycles == 20000) begin
      n_fail++;
      $display("[FAIL] %0t run did not finish", $time);
      final_report();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(drive_homing_pkg::OFS_STATUS, 32'h0000_0000);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0000);
    axi_wr(8'h3c, 32'h0000_0001, rs);
    chk_resp(rs, drive_homing_pkg::RESP_SLVERR);
    axi_rd(8'h34, rd, rs);
    chk_resp(rs, drive_homing_pkg::RESP_SLVERR);
    chk32(rd, 32'h0000_0000);
    wr_ok(drive_homing_pkg::OFS_ACT_POS, 32'h0000_abcd);
    rd_chk(drive_homing_pkg::OFS_ACT_POS, START_POS);
    // Command patterns, legal and illegal, from every state
    for (i = 0; i < 11; i++) begin
      wr_ok(drive_homing_pkg::OFS_CTRL, {28'h0, cmd_tab[i]});
      rd_chk(drive_homing_pkg::OFS_STATUS, {30'h0, st_tab[i]});
    end
    // Homing refused while not in positioning mode, then while the drive is disabled
    wr_ok(drive_homing_pkg::OFS_MODE_REQ, 32'h0000_0006);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0000);
    wr_ok(drive_homing_pkg::OFS_CTRL, 32'h0000_0000);
    wr_ok(drive_homing_pkg::OFS_MODE_REQ, 32'h0000_0001);
    wr_ok(drive_homing_pkg::OFS_MODE_REQ, 32'h0000_0006);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0001);
    rd_chk(drive_homing_pkg::OFS_STATUS, 32'h0000_0000);
    // Homing to the present position plus offset
    wr_ok(drive_homing_pkg::OFS_TARGET_VEL, 32'h0000_0000);
    wr_ok(drive_homing_pkg::OFS_HOME_OFFSET, 32'h0000_0010);
    wr_ok(drive_homing_pkg::OFS_HOME_METHOD, 32'h0000_0025);
    for (i = 8; i < 11; i++) begin
      wr_ok(drive_homing_pkg::OFS_CTRL, {28'h0, cmd_tab[i]});
    end
    rd_chk(drive_homing_pkg::OFS_STATUS, 32'h0000_0003);
    k = n_load;
    wr_ok(drive_homing_pkg::OFS_MODE_REQ, 32'h0000_0006);
    rd_chk(drive_homing_pkg::OFS_REF_POS, START_POS + 32'h0000_0010);
    chk32(ref_pos, START_POS + 32'h0000_0010);
    chk32(32'(n_load - k), 32'h0000_0001);
    rd_chk(drive_homing_pkg::OFS_ACT_POS, START_POS);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0001);
    // Homing to the reference switch
    wr_ok(drive_homing_pkg::OFS_HOME_POL, 32'h0000_0000);
    wr_ok(drive_homing_pkg::OFS_HOME_TARGET, 32'h0000_03e8);
    wr_ok(drive_homing_pkg::OFS_HOME_V1, 32'h0000_0004);
    wr_ok(drive_homing_pkg::OFS_HOME_V2, 32'h0000_0001);
    wr_ok(drive_homing_pkg::OFS_HOME_METHOD, 32'h0000_0011);
    k = n_load;
    wr_ok(drive_homing_pkg::OFS_MODE_REQ, 32'h0000_0006);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0006);
    rd_chk(drive_homing_pkg::OFS_STATUS, 32'h0000_0013);
    n = 0;
    while (n_load == k && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    chk32(32'(n_load - k), 32'h0000_0001);
    chk32({31'h0, seen_rev}, 32'h0000_0001);
    chk32({31'h0, seen_slow}, 32'h0000_0001);
    axi_rd(drive_homing_pkg::OFS_REF_POS, rd, rs);
    chk_resp(rs, drive_homing_pkg::RESP_OKAY);
    chk32({31'h0, rd >= 32'h0000_0064 && rd <= 32'h0000_006e}, 32'h0000_0001);
    rd_chk(drive_homing_pkg::OFS_ACT_POS, rd);
    rd_chk(drive_homing_pkg::OFS_MODE_ACT, 32'h0000_0001);
    rd_chk(drive_homing_pkg::OFS_STATUS, 32'h0000_0003);
    final_report();
  end
endmodule
